// ===== core/dram_strobe_refresh.sv
// dram address mux, row/column strobes, write enable and refresh control
// assumes access inputs and refresh extend are on clk_i; refresh request and disable pins are asynchronous and synchronised here
`timescale 1ns/10ps
module dram_strobe_refresh
  import dram_refresh_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                clk_en_i,
  input  wire logic                prog_load_i,
  input  wire logic                prog_pipeline_i,
  input  wire logic                prog_long_interval_i,
  input  wire logic                column_strobe_enable_0_i,
  input  wire logic                access_req_i,
  input  wire logic [STROBE_W-1:0] access_bank_sel_i,
  input  wire logic [ADDR_W-1:0]   row_addr_in_i,
  input  wire logic [ADDR_W-1:0]   column_addr_in_i,
  input  wire logic                write_in_i,
  input  wire logic                refresh_request_in_i,
  input  wire logic                internal_refresh_disable_i,
  input  wire logic                refresh_extend_i,
  output logic [ADDR_W-1:0]        dram_addr_out_o,
  output logic [STROBE_W-1:0]      row_strobe_out_o,
  output logic [STROBE_W-1:0]      column_strobe_out_o,
  output logic                     write_enable_o,
  output logic                     refresh_in_progress_o,
  output logic                     access_busy_o
);
  logic              rst_s1_q;
  logic              rst_b;
  logic              ext_req;
  logic              dis_ref;
  logic              ext_req_prev_q;
  logic              pipeline_q;
  logic              long_sel_q;
  logic              cse0_q;
  logic              due;
  logic              ref_done;
  logic              ext_pending_q;
  logic              want_refresh;
  logic [ADDR_W-1:0] ref_row_q;
  logic [2:0]        phase_q;
  ctrl_state_e       state_q;
  logic              ref_on_we;

  // reset release through two flip-flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_b    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b    <= rst_s1_q;
    end
  end

  // asynchronous refresh pins
  pin_sync u_sync_req (
    .clk_i   (clk_i),
    .rst_b_i (rst_b),
    .en_i    (clk_en_i),
    .pin_i   (refresh_request_in_i),
    .level_o (ext_req)
  );
  pin_sync u_sync_dis (
    .clk_i   (clk_i),
    .rst_b_i (rst_b),
    .en_i    (clk_en_i),
    .pin_i   (internal_refresh_disable_i),
    .level_o (dis_ref)
  );

  // programming settings captured while load is active
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pipeline_q <= 1'b0;
      long_sel_q <= 1'b0;
      cse0_q     <= 1'b1;
    end else if (clk_en_i && prog_load_i) begin
      pipeline_q <= prog_pipeline_i;
      long_sel_q <= prog_long_interval_i;
      cse0_q     <= column_strobe_enable_0_i;
    end
  end

  // interval timer sets the due flag
  refresh_timer u_timer (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b),
    .en_i       (clk_en_i),
    .long_sel_i (long_sel_q),
    .done_i     (ref_done),
    .due_o      (due)
  );

  // refresh ends when its precharge phase completes
  assign ref_done = (state_q == ST_REF_PRECH) && (phase_q == PH_ONE);

  // external request latch: rising edge under disable is one refresh
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ext_req_prev_q <= 1'b0;
      ext_pending_q  <= 1'b0;
    end else if (clk_en_i) begin
      ext_req_prev_q <= ext_req;
      if (dis_ref && ext_req && !ext_req_prev_q) begin
        ext_pending_q <= 1'b1;
      end else if (ref_done) begin
        ext_pending_q <= 1'b0;
      end
    end
  end

  // held request bursts, interval refresh only when not disabled
  assign want_refresh = dis_ref ? (ext_pending_q || ext_req)
                                : due;

  // refresh row counter
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ref_row_q <= ADDR_ZERO;
    end else if (clk_en_i) begin
      if (ext_req && !dis_ref) begin
        ref_row_q <= ADDR_ZERO;
      end else if (ref_done) begin
        ref_row_q <= ref_row_q + ADDR_ONE;
      end
    end
  end

  // controller sequencer with phase counter
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ZERO;
    end else if (clk_en_i) begin
      case (state_q)
        ST_IDLE: begin
          phase_q <= PH_ZERO;
          if (want_refresh) begin
            state_q <= ST_REF_SETUP;
            phase_q <= REF_SETUP_CYC;
          end else if (access_req_i) begin
            state_q <= ST_ACC_ROW;
            phase_q <= ACC_ROW_CYC;
          end
        end
        ST_REF_SETUP: begin
          if (phase_q == PH_ONE) begin
            state_q <= ST_REF_ROW;
            phase_q <= REF_ROW_CYC;
          end else begin
            phase_q <= phase_q - PH_ONE;
          end
        end
        ST_REF_ROW: begin
          if (phase_q == PH_ONE && !refresh_extend_i) begin
            state_q <= ST_REF_PRECH;
            phase_q <= REF_PRECH_CYC;
          end else if (phase_q != PH_ONE) begin
            phase_q <= phase_q - PH_ONE;
          end
        end
        ST_REF_PRECH: begin
          if (phase_q == PH_ONE) begin
            state_q <= ST_IDLE;
            phase_q <= PH_ZERO;
          end else begin
            phase_q <= phase_q - PH_ONE;
          end
        end
        ST_ACC_ROW: begin
          if (phase_q == PH_ONE) begin
            state_q <= ST_ACC_COL;
          end else begin
            phase_q <= phase_q - PH_ONE;
          end
        end
        ST_ACC_COL: begin
          if (!access_req_i) begin
            state_q <= ST_ACC_PRECH;
            phase_q <= ACC_PRECH_CYC;
          end
        end
        ST_ACC_PRECH: begin
          if (phase_q == PH_ONE) begin
            state_q <= ST_IDLE;
            phase_q <= PH_ZERO;
          end else begin
            phase_q <= phase_q - PH_ONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          phase_q <= PH_ZERO;
        end
      endcase
    end
  end

  // write-enable pin doubles as refresh request in some modes
  assign ref_on_we = pipeline_q || !cse0_q;

  // registered dram-side outputs
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      dram_addr_out_o       <= ADDR_ZERO;
      row_strobe_out_o      <= STROBE_NONE;
      column_strobe_out_o   <= STROBE_NONE;
      write_enable_o        <= 1'b0;
      refresh_in_progress_o <= 1'b0;
    end else if (clk_en_i) begin
      case (state_q)
        ST_REF_SETUP, ST_REF_ROW: begin
          dram_addr_out_o       <= ref_row_q;
          refresh_in_progress_o <= 1'b1;
          row_strobe_out_o      <= (state_q == ST_REF_ROW) ? STROBE_ALL : STROBE_NONE;
          column_strobe_out_o   <= STROBE_NONE;
        end
        ST_REF_PRECH: begin
          dram_addr_out_o       <= ref_row_q;
          row_strobe_out_o      <= STROBE_NONE;
          column_strobe_out_o   <= STROBE_NONE;
          refresh_in_progress_o <= 1'b0;
        end
        ST_ACC_ROW: begin
          dram_addr_out_o       <= row_addr_in_i;
          row_strobe_out_o      <= access_bank_sel_i;
          column_strobe_out_o   <= STROBE_NONE;
          refresh_in_progress_o <= 1'b0;
        end
        ST_ACC_COL: begin
          dram_addr_out_o       <= column_addr_in_i;
          row_strobe_out_o      <= access_bank_sel_i;
          column_strobe_out_o   <= access_bank_sel_i;
          refresh_in_progress_o <= 1'b0;
        end
        default: begin
          dram_addr_out_o       <= row_addr_in_i;
          row_strobe_out_o      <= STROBE_NONE;
          column_strobe_out_o   <= STROBE_NONE;
          refresh_in_progress_o <= 1'b0;
        end
      endcase
      if (ref_on_we) begin
        write_enable_o <= due;
      end else begin
        write_enable_o <= write_in_i;
      end
    end
  end

  assign access_busy_o = (state_q == ST_ACC_ROW) || (state_q == ST_ACC_COL)
                         || (state_q == ST_ACC_PRECH);

  // refresh row strobes rise only once the in-progress indicator is already up
  AST_RAS_UNDER_REFRESH_IN_PROGRESS: assert property (@(posedge clk_i) disable iff (!rst_b)
    (refresh_in_progress_o && (row_strobe_out_o != STROBE_NONE)
     && ($past(row_strobe_out_o) == STROBE_NONE))
    |-> $past(refresh_in_progress_o))
    else $error("refresh strobes without in-progress");
  // in-progress drops with all row strobes low
  AST_REFRESH_IN_PROGRESS_DROP: assert property (@(posedge clk_i) disable iff (!rst_b)
    $fell(refresh_in_progress_o) |-> row_strobe_out_o == STROBE_NONE)
    else $error("in-progress dropped with row strobe active");
  // refresh address on bus while in progress
  AST_REF_ADDR: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && state_q == ST_REF_ROW) |=> dram_addr_out_o == $past(ref_row_q))
    else $error("refresh address not driven");
  // disable suppresses interval refreshes
  AST_NO_INT_REF: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && state_q == ST_IDLE && dis_ref && !ext_req && !ext_pending_q)
    |=> state_q != ST_REF_SETUP)
    else $error("interval refresh while disabled");
  // due refresh starts promptly from idle
  AST_REF_START: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && state_q == ST_IDLE && due && !dis_ref) |=> state_q == ST_REF_SETUP)
    else $error("due refresh did not start");
  // counter clear on request without disable
  AST_ROW_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && ext_req && !dis_ref) |=> ref_row_q == ADDR_ZERO)
    else $error("refresh row not cleared");
  // counter advances after refresh
  AST_ROW_ADV: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && ref_done && !(ext_req && !dis_ref)) |=> ref_row_q == $past(ref_row_q) + ADDR_ONE)
    else $error("refresh row not advanced");
  // extend holds the row phase
  AST_EXTEND: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && state_q == ST_REF_ROW && refresh_extend_i) |=> state_q == ST_REF_ROW)
    else $error("refresh row phase not extended");
  // write enable follows write input in normal mode
  AST_WE_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_b)
    (clk_en_i && !ref_on_we) |=> write_enable_o == $past(write_in_i))
    else $error("write enable not following write input");
endmodule : dram_strobe_refresh

// ===== core/dram_refresh_pkg.sv
// package for the dram strobe and refresh control block
// assumes a 40 MHz controller clock and an 11-bit dram address bus
package dram_refresh_pkg;
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned ADDR_W         = 11;
  localparam int unsigned STROBE_W       = 4;
  localparam int unsigned INTERVAL_SHORT_US = 13;
  localparam int unsigned INTERVAL_LONG_US  = 15;
  // interval counts in clock cycles, exact products of microseconds and clock MHz
  localparam int unsigned INTERVAL_SHORT_CYC = INTERVAL_SHORT_US * CLK_MHZ;
  localparam int unsigned INTERVAL_LONG_CYC  = INTERVAL_LONG_US * CLK_MHZ;
  localparam int unsigned TMR_W          = 10;
  // refresh cycle phase lengths in clocks
  localparam logic [2:0] REF_SETUP_CYC   = 3'h1;
  localparam logic [2:0] REF_ROW_CYC     = 3'h3;
  localparam logic [2:0] REF_PRECH_CYC   = 3'h2;
  // access phase lengths in clocks
  localparam logic [2:0] ACC_ROW_CYC     = 3'h1;
  localparam logic [2:0] ACC_PRECH_CYC   = 3'h2;
  localparam logic [STROBE_W-1:0] STROBE_ALL  = 4'hF;
  localparam logic [STROBE_W-1:0] STROBE_NONE = 4'h0;
  localparam logic [ADDR_W-1:0]   ADDR_ZERO   = 11'h000;
  localparam logic [ADDR_W-1:0]   ADDR_ONE    = 11'h001;
  localparam logic [TMR_W-1:0]    TMR_ZERO    = 10'h000;
  localparam logic [TMR_W-1:0]    TMR_ONE     = 10'h001;
  localparam logic [2:0]          PH_ZERO     = 3'h0;
  localparam logic [2:0]          PH_ONE      = 3'h1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REF_SETUP, ST_REF_ROW, ST_REF_PRECH, ST_ACC_ROW, ST_ACC_COL, ST_ACC_PRECH
  } ctrl_state_e;
endpackage : dram_refresh_pkg

// ===== core/pin_sync.sv
// three-stage synchroniser with second/third agreement for pin inputs
// assumes clk_i is the controller clock and en_i the global clock enable
`timescale 1ns/10ps
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (en_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // change counts once second and third agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_o <= 1'b0;
    end else if (en_i && (s2_q == s3_q)) begin
      level_o <= s3_q;
    end
  end
endmodule : pin_sync

// ===== core/refresh_timer.sv
// refresh interval timer, raises a sticky due flag when the interval elapses
// assumes the clock enable is applied by the caller via en_i
`timescale 1ns/10ps
module refresh_timer
  import dram_refresh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  input  wire logic long_sel_i,
  input  wire logic done_i,
  output logic      due_o
);
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] limit;
  logic             expire;
  // interval selected by programmed setting
  assign limit  = long_sel_i ? TMR_W'(INTERVAL_LONG_CYC - 1) : TMR_W'(INTERVAL_SHORT_CYC - 1);
  assign expire = (cnt_q >= limit);
  // free-running interval counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= TMR_ZERO;
    end else if (en_i) begin
      cnt_q <= expire ? TMR_ZERO : cnt_q + TMR_ONE;
    end
  end
  // due flag, a new expiry wins over the clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      due_o <= 1'b0;
    end else if (en_i) begin
      if (expire) begin
        due_o <= 1'b1;
      end else if (done_i) begin
        due_o <= 1'b0;
      end
    end
  end
endmodule : refresh_timer

// ===== bench/dram_array_model.sv
// dram array model facing the strobe and refresh control block
// assumes active high strobes sampled on the controller clock
`timescale 1ns/10ps
module dram_array_model
  import dram_refresh_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic [ADDR_W-1:0]   dram_addr_i,
  input  wire logic [STROBE_W-1:0] row_strobe_i,
  input  wire logic                refresh_in_progress_i,
  output logic [ADDR_W-1:0]        ref_row_o,
  output logic [7:0]               ref_cnt_o
);
  logic [STROBE_W-1:0] row_q;

  // latch the refresh row on each rising row strobe while refresh is flagged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_q     <= 4'h0;
      ref_row_o <= 11'h000;
      ref_cnt_o <= 8'h00;
    end else begin
      row_q <= row_strobe_i;
      if ((row_q == 4'h0) && (row_strobe_i != 4'h0) && refresh_in_progress_i) begin
        ref_row_o <= dram_addr_i;
        ref_cnt_o <= ref_cnt_o + 8'h01;
      end
    end
  end
endmodule : dram_array_model

// ===== bench/tb.sv
// self-checking bench for the dram strobe and refresh control block
// assumes inputs change at the falling edge and the array model watches the pins
`timescale 1ns/10ps
module tb;
  import dram_refresh_pkg::*;
  logic                clk_i;
  logic                rst_b_i;
  logic                clk_en_i;
  logic                prog_load_i;
  logic                prog_pipeline_i;
  logic                prog_long_interval_i;
  logic                column_strobe_enable_0_i;
  logic                access_req_i;
  logic [STROBE_W-1:0] access_bank_sel_i;
  logic [ADDR_W-1:0]   row_addr_in_i;
  logic [ADDR_W-1:0]   column_addr_in_i;
  logic                write_in_i;
  logic                refresh_request_in_i;
  logic                internal_refresh_disable_i;
  logic                refresh_extend_i;
  logic [ADDR_W-1:0]   dram_addr_out_o;
  logic [STROBE_W-1:0] row_strobe_out_o;
  logic [STROBE_W-1:0] column_strobe_out_o;
  logic                write_enable_o;
  logic                refresh_in_progress_o;
  logic                access_busy;
  logic [ADDR_W-1:0]   ref_row;
  logic [7:0]          ref_cnt;
  int                  fails;
  int                  n_compared;
  int                  n;
  int                  k;

  dram_strobe_refresh DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .prog_load_i(prog_load_i), .prog_pipeline_i(prog_pipeline_i),
    .prog_long_interval_i(prog_long_interval_i),
    .column_strobe_enable_0_i(column_strobe_enable_0_i), .access_req_i(access_req_i),
    .access_bank_sel_i(access_bank_sel_i), .row_addr_in_i(row_addr_in_i),
    .column_addr_in_i(column_addr_in_i), .write_in_i(write_in_i),
    .refresh_request_in_i(refresh_request_in_i),
    .internal_refresh_disable_i(internal_refresh_disable_i),
    .refresh_extend_i(refresh_extend_i), .dram_addr_out_o(dram_addr_out_o),
    .row_strobe_out_o(row_strobe_out_o), .column_strobe_out_o(column_strobe_out_o),
    .write_enable_o(write_enable_o), .refresh_in_progress_o(refresh_in_progress_o),
    .access_busy_o(access_busy));

  dram_array_model array_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .dram_addr_i(dram_addr_out_o), .row_strobe_i(row_strobe_out_o),
    .refresh_in_progress_i(refresh_in_progress_o), .ref_row_o(ref_row), .ref_cnt_o(ref_cnt));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bounded wait: 0 refresh flag, 1 write enable, 2 any row strobe
  task automatic wait_sig(input int sel, input logic lvl, output int cnt);
    logic v;
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
      v = (sel == 0) ? refresh_in_progress_o : (sel == 1) ? write_enable_o : |row_strobe_out_o;
    end while (v !== lvl && cnt < 800);
    if (v !== lvl) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, v, lvl);
      end_of_test();
    end
  endtask : wait_sig

  task automatic load_mode(input logic pipe, input logic lg, input logic ce0);
    prog_pipeline_i = pipe;
    prog_long_interval_i = lg;
    column_strobe_enable_0_i = ce0;
    prog_load_i = 1'b1;
    @(negedge clk_i);
    prog_load_i = 1'b0;
  endtask : load_mode

  // one access with fixed row and column, write or read
  task automatic access(input logic wr);
    int c;
    access_bank_sel_i = 4'h5;
    row_addr_in_i = 11'h2A5;
    column_addr_in_i = 11'h15A;
    write_in_i = wr;
    access_req_i = 1'b1;
    wait_sig(2, 1'b1, c);
    chk(dram_addr_out_o, 11'h2A5);
    chk(row_strobe_out_o, 4'h5);
    chk(access_busy, 1'b1);
    @(negedge clk_i);
    chk(dram_addr_out_o, 11'h15A);
    chk(column_strobe_out_o, 4'h5);
    chk(write_enable_o, wr);
    access_req_i = 1'b0;
    wait_sig(2, 1'b0, c);
    chk(column_strobe_out_o, 4'h0);
  endtask : access

  // one external refresh, optionally stretched by the extend input
  task automatic ext_refresh(input logic ext);
    int c;
    refresh_request_in_i = 1'b1;
    refresh_extend_i = ext;
    wait_sig(0, 1'b1, c);
    chk(row_strobe_out_o, 4'h0);
    refresh_request_in_i = 1'b0;
    wait_sig(2, 1'b1, c);
    repeat (5) @(negedge clk_i);
    chk(row_strobe_out_o, ext ? 4'hF : 4'h0);
    refresh_extend_i = 1'b0;
    wait_sig(0, 1'b0, c);
    chk(row_strobe_out_o, 4'h0);
  endtask : ext_refresh

  // main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    rst_b_i = 1'b0;
    clk_en_i = 1'b1;
    {prog_load_i, prog_pipeline_i, prog_long_interval_i, access_req_i} = 4'h0;
    {write_in_i, refresh_request_in_i, refresh_extend_i} = 3'h0;
    column_strobe_enable_0_i = 1'b1;
    internal_refresh_disable_i = 1'b1;
    access_bank_sel_i = 4'h0;
    row_addr_in_i = 11'h000;
    column_addr_in_i = 11'h000;
    repeat (8) @(negedge clk_i);
    chk({row_strobe_out_o, column_strobe_out_o, refresh_in_progress_o}, 9'h000);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    load_mode(1'b0, 1'b0, 1'b1);
    // a low clock enable freezes the sequencer, so a pending access does not start
    clk_en_i = 1'b0;
    access_bank_sel_i = 4'h5;
    access_req_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({row_strobe_out_o, access_busy}, 5'h00);
    clk_en_i = 1'b1;
    access_req_i = 1'b0;
    @(negedge clk_i);
    access(1'b1);
    access(1'b0);
    // refresh request shown on write enable in pipelining mode
    load_mode(1'b1, 1'b0, 1'b1);
    wait_sig(1, 1'b1, n);
    repeat (10) @(negedge clk_i);
    chk(ref_cnt, 8'h00);
    ext_refresh(1'b0);
    chk(ref_cnt, 8'h01);
    chk(ref_row, 11'h000);
    repeat (3) @(negedge clk_i);
    chk(write_enable_o, 1'b0);
    load_mode(1'b0, 1'b0, 1'b0);
    wait_sig(1, 1'b1, n);
    ext_refresh(1'b1);
    // held request gives a burst
    refresh_request_in_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, n);
    end
    refresh_request_in_i = 1'b0;
    repeat (20) @(negedge clk_i);
    chk(ref_cnt > 8'h04, 1'b1);
    chk(ref_row, ref_cnt - 8'h01);
    // pending interval refresh runs once disable drops
    load_mode(1'b0, 1'b1, 1'b0);
    wait_sig(1, 1'b1, n);
    internal_refresh_disable_i = 1'b0;
    wait_sig(0, 1'b1, n);
    chk(n < 12, 1'b1);
    wait_sig(0, 1'b0, n);
    refresh_request_in_i = 1'b1;
    repeat (6) @(negedge clk_i);
    refresh_request_in_i = 1'b0;
    wait_sig(0, 1'b1, n);
    wait_sig(2, 1'b1, n);
    chk(dram_addr_out_o, 11'h000);
    // rise to rise period for both programmed intervals
    for (int i = 0; i < 2; i++) begin
      load_mode(1'b0, i == 0, 1'b1);
      wait_sig(0, 1'b0, n);
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, n);
      wait_sig(0, 1'b1, k);
      chk(n + k, (i == 0) ? INTERVAL_LONG_CYC : INTERVAL_SHORT_CYC);
    end
    end_of_test();
  end
endmodule : tb
